// *** hdl/vstr_pkg.sv ***
package vstr_pkg;
    // Clock rate of aclk
    localparam int CLK_MHZ = 250;
    // Backplane timeout intervals, microseconds
    localparam int TMO_SHORT_US = 100;
    localparam int TMO_MID_US   = 200;
    localparam int TMO_LONG_US  = 400;
    // Same intervals in aclk cycles
    localparam int TMO_SHORT_CYC = TMO_SHORT_US * CLK_MHZ;
    localparam int TMO_MID_CYC   = TMO_MID_US * CLK_MHZ;
    localparam int TMO_LONG_CYC  = TMO_LONG_US * CLK_MHZ;
    // Timer width, holds the longest interval
    localparam int TMR_W = 17;
    // Register byte offsets
    localparam int AXI_AW = 8;
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STAT     = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_EN   = 8'h0c;
    localparam logic [7:0] REG_IRQ_CLR  = 8'h10;
    // Control field positions
    localparam int CTRL_IVL_LSB   = 0;
    localparam int CTRL_LVL_LSB   = 2;
    localparam int CTRL_MON_BIT   = 4;
    localparam int CTRL_CHAIN_LSB = 5;
    // Interval selector codes
    localparam logic [1:0] IVL_OFF = 2'h0;
    localparam logic [1:0] IVL_100 = 2'h1;
    localparam logic [1:0] IVL_200 = 2'h2;
    localparam logic [1:0] IVL_400 = 2'h3;
    // Control reset values
    localparam logic [1:0] CTRL_IVL_RST   = IVL_100;
    localparam logic [1:0] CTRL_LVL_RST   = 2'h3;
    localparam logic       CTRL_MON_RST   = 1'b1;
    localparam logic [1:0] CTRL_CHAIN_RST = 2'h0;
    // Interrupt status bits
    localparam int IRQ_W         = 2;
    localparam int IRQ_TMO_BIT   = 0;
    localparam int IRQ_GRANT_BIT = 1;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Requester states
    typedef enum logic [1:0] {RQ_IDLE, RQ_WAIT, RQ_OWN} vstr_rq_t;
endpackage

// *** hdl/vstr_tmr_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface vstr_tmr_if;
    import vstr_pkg::*;
    logic             clear;   // Restart count
    logic             run;     // Count this cycle
    logic [TMR_W-1:0] limit;   // Cycles until expiry
    logic             expired; // Interval elapsed
    modport ctl (output clear, output run, output limit, input expired);
    modport tmr (input clear, input run, input limit, output expired);
endinterface // vstr_tmr_if
`default_nettype wire

// *** hdl/vstr_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module vstr_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] IDLE = '1 // Level of each pin while idle
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] d,
    output logic [W-1:0]      q
);
    typedef struct packed {
        logic [W-1:0] s1; // First stage, read only by s2
        logic [W-1:0] s2; // Second stage
    } vstr_sync_st_t;
    vstr_sync_st_t st_q;
    vstr_sync_st_t st_d;

    // Two-stage shift
    always_comb begin
        st_d    = st_q;
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
    end

    // Both stages start at the idle level, so no false event follows reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= {IDLE, IDLE};
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.s2;
endmodule // vstr_sync
`default_nettype wire

// *** hdl/vstr_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module vstr_timer (
    input  wire logic aclk,
    input  wire logic aresetn,
    vstr_tmr_if.tmr   tif
);
    import vstr_pkg::*;
    typedef struct packed {
        logic [TMR_W-1:0] cnt;     // Elapsed cycles
        logic             expired; // Sticky until clear
    } vstr_tmr_st_t;
    vstr_tmr_st_t st_q;
    vstr_tmr_st_t st_d;

    // Count while running, stop at limit
    always_comb begin
        st_d = st_q;
        if (tif.clear) begin
            st_d = '0; // R12
        end else if (tif.run && !st_q.expired) begin
            if (st_q.cnt == tif.limit - TMR_W'(1)) begin
                st_d.expired = 1'b1;
            end else begin
                st_d.cnt = st_q.cnt + TMR_W'(1);
            end
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tif.expired = st_q.expired;

    chk_timer_clear_restart: assert property (@(posedge aclk) disable iff (!aresetn) // R12
        tif.clear |=> (st_q.cnt == '0) && !st_q.expired)
        else $error("timer not cleared");
    chk_timer_exact_expiry: assert property (@(posedge aclk) disable iff (!aresetn) // R01
        $rose(st_q.expired) |-> $past(st_q.cnt) == $past(tif.limit) - TMR_W'(1))
        else $error("timer expired at wrong count");
endmodule // vstr_timer
`default_nettype wire

// *** hdl/vstr_top.sv ***
`timescale 1ns/100ps
`default_nettype none
// Operation
// R01 - BERR when strobe unanswered within interval
// R02 - Interval: off, 100, 200, 400 us
// R03 - Interval defaults to 100 us
// R04 - No timeout during any cable transfer
// R05 - Only one extender runs the monitor
// R06 - First-slot extender should hold the monitor
// R07 - Siblings signal outward transfers; monitor pauses
// R08 - Chain position picks local-bus lines
// R09 - First-slot controller keeps its timeout off
// R10 - Request bus for inward remote transfers
// R11 - Four request levels, level 3 default
// R12 - Timer restarts per strobe, stops on release
module vstr_top #(
    parameter int TMO_100_CYC = vstr_pkg::TMO_SHORT_CYC, // 100 us in cycles
    parameter int TMO_200_CYC = vstr_pkg::TMO_MID_CYC,   // 200 us in cycles
    parameter int TMO_400_CYC = vstr_pkg::TMO_LONG_CYC   // 400 us in cycles
) (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [vstr_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [vstr_pkg::AXI_AW-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    input  wire logic                      ds0_n_i,
    input  wire logic                      ds1_n_i,
    input  wire logic                      dtack_n_i,
    input  wire logic                      berr_n_i,
    output logic                           berr_n_o,
    output logic                           berr_n_oe,
    output logic [3:0]                     br_n_o,
    output logic [3:0]                     br_n_oe,
    input  wire logic                      bg_n_i,
    output logic                           bbsy_n_o,
    output logic                           bbsy_n_oe,
    input  wire logic                      remote_req_i,
    input  wire logic                      outward_busy_i,
    input  wire logic                      lbus_left_n_i,
    output logic                           lbus_left_n_o,
    output logic                           lbus_left_n_oe,
    input  wire logic                      lbus_right_n_i,
    output logic                           lbus_right_n_o,
    output logic                           lbus_right_n_oe,
    output logic                           irq
);
    import vstr_pkg::*;

    // Positions in the synchronised pin vector
    localparam int PIN_DS0   = 0;
    localparam int PIN_DS1   = 1;
    localparam int PIN_DTACK = 2;
    localparam int PIN_BERR  = 3;
    localparam int PIN_BG    = 4;
    localparam int PIN_RREQ  = 5;
    localparam int PIN_OUTB  = 6;
    localparam int PIN_LEFT  = 7;
    localparam int PIN_RIGHT = 8;
    localparam int PIN_W     = 9;
    // Idle levels: strobes, acks, grant and neighbour lines high, request and outward low
    localparam logic [PIN_W-1:0] PIN_IDLE = 9'h19f;

    typedef struct packed {
        logic [1:0]       ivl;      // Timeout interval selector
        logic [1:0]       lvl;      // Request level
        logic             mon;      // Monitor enable
        logic [1:0]       chain;    // Neighbour left / right
        logic [IRQ_W-1:0] irq_stat; // Sticky events
        logic [IRQ_W-1:0] irq_en;   // Event enables
        logic             irq;      // Interrupt line
        logic             aw_have;  // Write address held
        logic [7:0]       awaddr;   // Held write address
        logic             awready;  // Ready for address
        logic             w_have;   // Write data held
        logic [31:0]      wdata;    // Held write data
        logic [3:0]       wstrb;    // Held strobes
        logic             wready;   // Ready for data
        logic             bvalid;   // Write response pending
        logic [1:0]       bresp;    // Write response code
        logic             arready;  // Ready for read address
        logic             rvalid;   // Read data pending
        logic [31:0]      rdata;    // Read data
        logic [1:0]       rresp;    // Read response code
        logic             ds_act;   // Strobe active last cycle
        logic             berr_drv; // Driving BERR
        vstr_rq_t         rq;       // Requester state
        logic [3:0]       br_drv;   // Request lines driven
        logic             bbsy_drv; // Bus busy driven
        logic             left_drv; // Indication to left
        logic             right_drv; // Indication to right
        logic             supp;     // Timeout suppressed
    } vstr_st_t;

    vstr_st_t         st_q;
    vstr_st_t         st_d;
    logic [PIN_W-1:0] pins_s; // Synchronised pins
    vstr_tmr_if       tif ();

    // One-hot request line for a level
    function automatic logic [3:0] lvl_onehot(input logic [1:0] lvl);
        lvl_onehot = 4'h1 << lvl;
    endfunction

    // Interval code to cycle limit
    function automatic logic [TMR_W-1:0] ivl_limit(input logic [1:0] ivl);
        unique case (ivl)
            IVL_100: ivl_limit = TMR_W'(TMO_100_CYC);
            IVL_200: ivl_limit = TMR_W'(TMO_200_CYC);
            IVL_400: ivl_limit = TMR_W'(TMO_400_CYC);
            IVL_OFF: ivl_limit = '1;
        endcase
    endfunction

    // Every backplane and link pin crosses two flops
    vstr_sync #(
        .W    (PIN_W),
        .IDLE (PIN_IDLE)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({lbus_right_n_i, lbus_left_n_i, outward_busy_i, remote_req_i,
                   bg_n_i, berr_n_i, dtack_n_i, ds1_n_i, ds0_n_i}),
        .q       (pins_s)
    );

    // Interval timer
    vstr_timer u_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tif     (tif.tmr)
    );

    // Decoded backplane conditions
    logic ds_act;   // Either data strobe low
    logic answered; // Slave acked or errored
    logic armed;    // Monitor on and interval set
    logic sibling;  // Neighbour reports outward transfer
    logic outward;  // Own outward transfer
    assign ds_act   = !pins_s[PIN_DS0] || !pins_s[PIN_DS1];
    assign answered = !pins_s[PIN_DTACK] || !pins_s[PIN_BERR];
    assign armed    = st_q.mon && (st_q.ivl != IVL_OFF); // R02 R05
    assign sibling  = (st_q.chain[0] && !pins_s[PIN_LEFT])
                   || (st_q.chain[1] && !pins_s[PIN_RIGHT]); // R08
    assign outward  = pins_s[PIN_OUTB];

    // Timer restarts on each new strobe, halts when idle or suppressed
    assign tif.clear = !ds_act || !st_q.ds_act || answered || st_q.supp || !armed; // R12 R04
    assign tif.run   = ds_act && !answered; // R01
    assign tif.limit = ivl_limit(st_q.ivl); // R02

    // Next-state logic
    always_comb begin
        logic [IRQ_W-1:0] ev;  // Events this cycle
        logic [IRQ_W-1:0] clr; // Clear mask from software
        ev     = '0;
        clr    = '0;
        st_d   = st_q;

        // Write channel capture
        if (s_axi_awvalid && st_q.awready) begin
            st_d.aw_have = 1'b1;
            st_d.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_q.wready) begin
            st_d.w_have = 1'b1;
            st_d.wdata  = s_axi_wdata;
            st_d.wstrb  = s_axi_wstrb;
        end
        // Response accepted
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        // Perform write once both halves held
        if (st_q.aw_have && st_q.w_have && !st_q.bvalid) begin
            st_d.aw_have = 1'b0;
            st_d.w_have  = 1'b0;
            st_d.bvalid  = 1'b1;
            st_d.bresp   = RESP_OKAY;
            unique case (st_q.awaddr)
                REG_CTRL: begin
                    if (st_q.wstrb[0]) begin
                        st_d.ivl   = st_q.wdata[CTRL_IVL_LSB +: 2];   // R02
                        st_d.lvl   = st_q.wdata[CTRL_LVL_LSB +: 2];   // R11
                        st_d.mon   = st_q.wdata[CTRL_MON_BIT];        // R05
                        st_d.chain = st_q.wdata[CTRL_CHAIN_LSB +: 2]; // R08
                    end
                end
                REG_IRQ_EN: begin
                    if (st_q.wstrb[0]) begin
                        st_d.irq_en = st_q.wdata[IRQ_W-1:0];
                    end
                end
                REG_IRQ_CLR: begin
                    if (st_q.wstrb[0]) begin
                        clr = st_q.wdata[IRQ_W-1:0];
                    end
                end
                REG_STAT, REG_IRQ_STAT: begin
                    st_d.bresp = RESP_OKAY; // Read-only, write ignored
                end
                default: begin
                    st_d.bresp = RESP_SLVERR; // Unmapped
                end
            endcase
        end
        st_d.awready = !st_d.aw_have && !st_d.bvalid;
        st_d.wready  = !st_d.w_have && !st_d.bvalid;

        // Read channel
        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_q.arready) begin
            st_d.rvalid = 1'b1;
            st_d.rresp  = RESP_OKAY;
            st_d.rdata  = '0;
            unique case (s_axi_araddr)
                REG_CTRL: begin
                    st_d.rdata[CTRL_IVL_LSB +: 2]   = st_q.ivl;
                    st_d.rdata[CTRL_LVL_LSB +: 2]   = st_q.lvl;
                    st_d.rdata[CTRL_MON_BIT]        = st_q.mon;
                    st_d.rdata[CTRL_CHAIN_LSB +: 2] = st_q.chain;
                end
                REG_STAT: begin
                    st_d.rdata[3:0] = {st_q.bbsy_drv, |st_q.br_drv, st_q.supp, st_q.berr_drv};
                end
                REG_IRQ_STAT: begin
                    st_d.rdata[IRQ_W-1:0] = st_q.irq_stat;
                end
                REG_IRQ_EN: begin
                    st_d.rdata[IRQ_W-1:0] = st_q.irq_en;
                end
                REG_IRQ_CLR: begin
                    st_d.rdata = '0; // Write-only, reads zero
                end
                default: begin
                    st_d.rresp = RESP_SLVERR; // Unmapped
                end
            endcase
        end
        st_d.arready = !st_d.rvalid;

        // Requester: ask on the chosen level, hold busy while owning
        unique case (st_q.rq)
            RQ_IDLE: begin
                if (pins_s[PIN_RREQ]) begin
                    st_d.rq = RQ_WAIT; // R10
                end
            end
            RQ_WAIT: begin
                if (!pins_s[PIN_RREQ]) begin
                    st_d.rq = RQ_IDLE; // Remote master gave up
                end else if (!pins_s[PIN_BG]) begin
                    st_d.rq = RQ_OWN;
                    ev[IRQ_GRANT_BIT] = 1'b1;
                end
            end
            RQ_OWN: begin
                if (!pins_s[PIN_RREQ]) begin
                    st_d.rq = RQ_IDLE;
                end
            end
        endcase
        st_d.br_drv   = (st_d.rq == RQ_WAIT) ? lvl_onehot(st_q.lvl) : 4'h0; // R11
        st_d.bbsy_drv = (st_d.rq == RQ_OWN);

        // Suppress timeout for inward, own outward and sibling transfers
        st_d.supp = (st_q.rq != RQ_IDLE) || outward || (st_q.mon && sibling); // R04 R07

        // Non-monitor extenders relay outward indication toward neighbours
        st_d.left_drv  = !st_q.mon && st_q.chain[0]
                      && (outward || (st_q.chain[1] && !pins_s[PIN_RIGHT])); // R07 R08
        st_d.right_drv = !st_q.mon && st_q.chain[1]
                      && (outward || (st_q.chain[0] && !pins_s[PIN_LEFT]));  // R07 R08

        // BERR from expiry until the strobes release
        st_d.ds_act = ds_act;
        if (!ds_act) begin
            st_d.berr_drv = 1'b0; // R12
        end else if (tif.expired && armed && !st_q.supp) begin
            st_d.berr_drv = 1'b1; // R01
            if (!st_q.berr_drv) begin
                ev[IRQ_TMO_BIT] = 1'b1;
            end
        end

        // Sticky status, set wins over clear
        st_d.irq_stat = (st_q.irq_stat & ~clr) | ev;
        st_d.irq      = |(st_d.irq_stat & st_d.irq_en);
    end

    // State register and reset defaults
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q       <= '0;
            st_q.ivl   <= CTRL_IVL_RST; // R03
            st_q.lvl   <= CTRL_LVL_RST; // R11
            st_q.mon   <= CTRL_MON_RST; // R05 R06
            st_q.chain <= CTRL_CHAIN_RST;
            st_q.rq    <= RQ_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from flops; open-drain pins drive low when enabled
    assign s_axi_awready   = st_q.awready;
    assign s_axi_wready    = st_q.wready;
    assign s_axi_bvalid    = st_q.bvalid;
    assign s_axi_bresp     = st_q.bresp;
    assign s_axi_arready   = st_q.arready;
    assign s_axi_rvalid    = st_q.rvalid;
    assign s_axi_rdata     = st_q.rdata;
    assign s_axi_rresp     = st_q.rresp;
    assign berr_n_o        = 1'b0;
    assign berr_n_oe       = st_q.berr_drv;
    assign br_n_o          = 4'h0;
    assign br_n_oe         = st_q.br_drv;
    assign bbsy_n_o        = 1'b0;
    assign bbsy_n_oe       = st_q.bbsy_drv;
    assign lbus_left_n_o   = 1'b0;
    assign lbus_left_n_oe  = st_q.left_drv;
    assign lbus_right_n_o  = 1'b0;
    assign lbus_right_n_oe = st_q.right_drv;
    assign irq             = st_q.irq;

    chk_berr_needs_expiry: assert property (@(posedge aclk) disable iff (!aresetn) // R01
        $rose(st_q.berr_drv) |-> $past(tif.expired) && $past(ds_act) && $past(armed))
        else $error("BERR without timed-out strobe");
    chk_berr_off_disabled: assert property (@(posedge aclk) disable iff (!aresetn) // R02
        (st_q.ivl == IVL_OFF) ##1 (st_q.ivl == IVL_OFF) |-> !$rose(st_q.berr_drv))
        else $error("BERR while interval disabled");
    chk_reset_defaults: assert property (@(posedge aclk) // R03
        !aresetn |=> (st_q.ivl == IVL_100) && (st_q.lvl == 2'h3) && (st_q.rq == RQ_IDLE))
        else $error("reset defaults wrong");
    chk_suppress_berr: assert property (@(posedge aclk) disable iff (!aresetn) // R04
        st_q.supp |=> !$rose(st_q.berr_drv))
        else $error("BERR during cable transfer");
    chk_monitor_only_berr: assert property (@(posedge aclk) disable iff (!aresetn) // R05
        !st_q.mon ##1 !st_q.mon |-> !$rose(st_q.berr_drv))
        else $error("BERR from non-monitor extender");
    chk_sibling_relay: assert property (@(posedge aclk) disable iff (!aresetn) // R07
        (!st_q.mon && st_q.chain[0] && outward) |=> st_q.left_drv)
        else $error("outward indication not driven");
    chk_remote_request: assert property (@(posedge aclk) disable iff (!aresetn) // R10
        (st_q.rq == RQ_IDLE && pins_s[PIN_RREQ]) |=> ##1 (st_q.br_drv == lvl_onehot($past(st_q.lvl, 2))))
        else $error("bus not requested");
    chk_request_level: assert property (@(posedge aclk) disable iff (!aresetn) // R11
        (st_q.br_drv != 4'h0) |-> $onehot(st_q.br_drv) && !st_q.bbsy_drv)
        else $error("request on bad level");
    chk_release_clears: assert property (@(posedge aclk) disable iff (!aresetn) // R12
        !ds_act |=> !st_q.berr_drv ##1 !tif.expired)
        else $error("BERR or timer held after strobe release");
endmodule // vstr_top
`default_nettype wire

// *** testbench/vstr_bp_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module vstr_bp_model (
    input  wire logic       aclk,
    input  wire logic       ds_n,
    input  wire logic       ack_en,
    input  wire logic [3:0] br_n_oe,
    output logic            dtack_n,
    output logic            bg_n
);
    // Slave answers a strobe one cycle later when told to; pull-up when idle
    // Arbiter grants one cycle after any request line is pulled
    always_ff @(posedge aclk) begin
        dtack_n <= !(ack_en && !ds_n);
        bg_n    <= !(|br_n_oe);
    end
endmodule // vstr_bp_model
`default_nettype wire

// *** testbench/vstr_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module vstr_top_tb;
    import vstr_pkg::*;
    logic        aclk = 0, aresetn = 0, ds_n = 1, ack_en = 0, remote = 0, outward = 0;
    logic        ds1_n = 1, left_n = 1, right_n = 1, use1 = 0, left_oe, right_oe;
    logic        awvalid = 0, wvalid = 0, arvalid = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, v;
    logic [1:0]  bresp, rresp, rs;
    logic [3:0]  br_oe, b;
    logic        awready, wready, bvalid, arready, rvalid, berr_oe, bbsy_oe, irq, dtack_n, bg_n;
    int          failures = 0, checks_done = 0, cyc = 0, n;
    // 250 MHz clock
    always #2 aclk = ~aclk;
    // Only this block pulls the error line
    vstr_top #(.TMO_100_CYC(20), .TMO_200_CYC(40), .TMO_400_CYC(80)) i_dut (
        .aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .ds0_n_i(ds_n), .ds1_n_i(ds1_n),
        .dtack_n_i(dtack_n), .berr_n_i(!berr_oe), .berr_n_o(), .berr_n_oe(berr_oe), .br_n_o(),
        .br_n_oe(br_oe), .bg_n_i(bg_n), .bbsy_n_o(), .bbsy_n_oe(bbsy_oe), .remote_req_i(remote),
        .outward_busy_i(outward), .lbus_left_n_i(left_n), .lbus_left_n_o(), .lbus_left_n_oe(left_oe),
        .lbus_right_n_i(right_n), .lbus_right_n_o(), .lbus_right_n_oe(right_oe), .irq);
    // Backplane slave and arbiter
    vstr_bp_model i_bp (.aclk, .ds_n(ds_n && ds1_n), .ack_en, .br_n_oe(br_oe), .dtack_n, .bg_n);
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Write one word, address and data offered together
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
    endtask
    // Read one word
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
    endtask
    // Hold an unanswered strobe, count cycles until the error line, then release
    task automatic strobe(output int c);
        ds_n  <= use1;
        ds1_n <= !use1;
        c = 0;
        do begin
            @(posedge aclk);
            c++;
        end while (!berr_oe && c < 120);
        ds_n  <= 1'b1;
        ds1_n <= 1'b1;
        repeat (6) @(posedge aclk);
        chk(berr_oe, 0);
    endtask
    // Verdict
    task automatic summarize();
        $display("%0d checks, %0d failures", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            failures++;
            summarize();
        end
    end
    // Test sequence
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(REG_CTRL, v, rs);
        chk(v, 32'h1d);
        axi_rd(8'h40, v, rs);
        chk(rs, RESP_SLVERR);
        axi_wr(8'h40, 32'h0, rs);
        chk(rs, RESP_SLVERR);
        axi_wr(REG_IRQ_EN, 32'h3, rs);
        $display("test 1 done");
        // Each interval: expiry time, interrupt, clear
        for (int i = 1; i < 4; i++) begin
            axi_wr(REG_CTRL, {28'h1, 2'h3, 2'(i)}, rs);
            use1 = (i == 2);
            strobe(n);
            chk(n >= (10 << i) + 2 && n <= (10 << i) + 8, 1);
            chk(irq, 1);
            axi_wr(REG_IRQ_CLR, 32'h1, rs);
            @(posedge aclk);
            chk(irq, 0);
        end
        $display("test 2 done");
        // Off, monitor disabled, answered, outward transfer
        for (int k = 0; k < 4; k++) begin
            axi_wr(REG_CTRL, {27'h0, k != 1, 2'h3, (k == 0) ? IVL_OFF : IVL_100}, rs);
            ack_en  <= (k == 2);
            outward <= (k == 3);
            strobe(n);
            chk(n, 120);
        end
        ack_en  <= 1'b0;
        outward <= 1'b0;
        $display("test 3 done");
        // Every request level
        for (int l = 0; l < 4; l++) begin
            axi_wr(REG_CTRL, {28'h1, 2'(l), IVL_100}, rs);
            remote <= 1'b1;
            n = 0;
            b = 4'h0;
            do begin
                @(posedge aclk);
                n++;
                if (br_oe !== 4'h0) b = br_oe;
            end while (!bbsy_oe && n < 20);
            chk(b, 4'h1 << l);
            chk(bbsy_oe, 1);
            axi_rd(REG_IRQ_STAT, v, rs);
            chk(v[IRQ_GRANT_BIT], 1);
            axi_wr(REG_IRQ_CLR, 32'h2, rs);
            remote <= 1'b0;
            repeat (6) @(posedge aclk);
            chk(bbsy_oe, 0);
        end
        $display("test 4 done");
        // Neighbour indication on each side pauses the monitor, then relay both ways
        for (int j = 0; j < 2; j++) begin
            axi_wr(REG_CTRL, {25'h0, 2'(j + 1), 1'b1, 2'h3, IVL_100}, rs);
            left_n  <= (j != 0);
            right_n <= (j != 1);
            strobe(n);
            chk(n, 120);
        end
        left_n  <= 1'b1;
        right_n <= 1'b1;
        axi_wr(REG_CTRL, {25'h0, 2'h3, 1'b0, 2'h3, IVL_100}, rs);
        outward <= 1'b1;
        repeat (4) @(posedge aclk);
        chk({left_oe, right_oe}, 2'h3);
        outward <= 1'b0;
        $display("test 5 done");
        summarize();
    end
endmodule // vstr_top_tb
`default_nettype wire
